/* verilog/bmsl_pkg.sv */
// ****************************************************************
// Shared constants of the size and lane encoder.
// ****************************************************************
package bmsl_pkg;
  // Bus and request widths.
  localparam int ADDR_W = 32; // Processor-bus address width.
  localparam int LEN_W = 16; // Request byte-count width.
  localparam int LANES = 8; // Byte lanes of the 64-bit data path.
  // Transfer lengths in bytes.
  localparam logic [15:0] BEAT_BYTES = 16'h0008; // One doubleword.
  localparam logic [15:0] EXT_DBL_BYTES = 16'h0010; // Extended double.
  localparam logic [15:0] EXT_TRI_BYTES = 16'h0018; // Extended triple.
  localparam logic [15:0] BURST_BYTES = 16'h0020; // Four-doubleword burst.
  localparam logic [4:0] LINE_MASK = 5'h1f; // Offset bits inside a line.
  // Size field encodings.
  localparam logic [2:0] LOW_DW = 3'h0; // Eight-byte single beat.
  localparam logic [2:0] LOW_EXT_DBL = 3'h1; // Sixteen-byte extended.
  localparam logic [2:0] LOW_EXT_TRI = 3'h2; // Twenty-four-byte extended.
  localparam logic [2:0] LOW_BURST = 3'h2; // Burst code.
  localparam logic [7:0] ALL_LANES = 8'hff; // Every lane in use.
  // Descriptor: address, burst_n, extended bit, low code, lanes.
  localparam int DESC_W = ADDR_W + 1 + 1 + 3 + LANES; // Queue width.
  localparam int FIFO_DEPTH = 8; // Queue depth in descriptors.
endpackage : bmsl_pkg

/* verilog/bmsl_size_lane_encoder.sv */
// How it works
// - Bursts drive the burst indicator low.
// - Single and extended beats keep indicator high.
// - Extended sizes only when extension is enabled.
// - A configuration bit disables the extended sizes.
// - Singles: extra bit 0, code 1-7, 0=8.
// - Extended: extra bit 1, 001=16, 010=24.
// - Burst: indicator low, extra 0, code 010.
// - All slaves have a 64-bit data path.
// - Requests split into legal size/alignment pieces.
// - Offset n selects lane n, lane 0 first.
// - N bytes at k use lanes k..k+N-1.
// - Singles never pass lane seven.
// - Mix singles, extended and bursts for any length.
// - Lane choice ignores endian configuration.
// - Bursts start only on 32-byte lines.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Descriptor queue.
// ****************************************************************
module bmsl_fifo #(
  parameter int WIDTH = bmsl_pkg::DESC_W, // Word width.
  parameter int DEPTH = bmsl_pkg::FIFO_DEPTH // Word count.
) (
  input wire logic clk, // Bus clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Offered word.
  output logic out_valid, // Word waiting.
  input wire logic out_ready, // Drain side takes the word.
  output logic [WIDTH-1:0] out_data // Oldest word.
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width.
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH); // Full count.
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1); // Last slot.

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage.
    logic [AW-1:0] wp; // Write slot.
    logic [AW-1:0] rp; // Read slot.
    logic [AW:0] cnt; // Words held.
  } bmsl_fifo_st_t;

  bmsl_fifo_st_t st_q; // Registered state.
  bmsl_fifo_st_t st_d; // Next state.
  logic push; // Word written this cycle.
  logic pop; // Word read this cycle.

  // Full and empty come straight from the count, so both are honest.
  assign in_ready = (st_q.cnt != FULL);
  assign out_valid = (st_q.cnt != '0);
  assign out_data = st_q.mem[st_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at the last slot, so any depth works.
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = (st_q.wp == LAST) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == LAST) ? '0 : st_q.rp + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.cnt <= FULL)
    else $error("Queue count beyond depth.");
endmodule : bmsl_fifo

// ****************************************************************
// Request splitter and size/lane encoder.
// ****************************************************************
module bmsl_size_lane_encoder #(
  parameter int DEPTH = bmsl_pkg::FIFO_DEPTH // Descriptor queue depth.
) (
  input wire logic CLK, // Bus clock, 100 MHz.
  input wire logic RST_N, // Synchronous reset, active low.
  input wire logic EXTENDED_CYCLE_ENABLE, // Allows 16/24-byte cycles.
  input wire logic REQ_VALID, // Transfer request offered.
  output logic REQ_READY, // Splitter idle, takes a request.
  input wire logic [31:0] REQ_ADDR, // First byte address.
  input wire logic [15:0] REQ_LEN, // Byte count.
  output logic BUSY, // Request being split.
  output logic TXN_VALID, // Bus transaction waiting.
  input wire logic TXN_READY, // Bus takes the transaction.
  output logic [31:0] TXN_ADDR, // Transaction address.
  output logic BURST_INDICATOR_N, // Low for a burst.
  output logic EXTENDED_SIZE_BIT, // High for an extended cycle.
  output logic [2:0] LOW_SIZE_CODE, // Low three size bits.
  output logic [7:0] LANE_EN // Bit n set when lane n carries data.
);
  typedef struct packed {
    logic busy_q; // Splitting in progress.
    logic rdy_q; // Request port open.
    logic ext_en_q; // Extension enable caught with the request.
    logic [31:0] addr_q; // Next byte to cover.
    logic [15:0] rem_q; // Bytes still to cover.
    logic ov_q; // Output stage full.
    logic [31:0] oaddr_q; // Output address.
    logic oburst_n_q; // Output burst indicator.
    logic oext_q; // Output extended bit.
    logic [2:0] olow_q; // Output low size code.
    logic [7:0] olane_q; // Output lanes.
  } bmsl_st_t;

  localparam bmsl_st_t RESET_ST = '{busy_q: 1'b0, rdy_q: 1'b1,
    ext_en_q: 1'b0, addr_q: '0, rem_q: '0, ov_q: 1'b0, oaddr_q: '0,
    oburst_n_q: 1'b1, oext_q: 1'b0, olow_q: '0, olane_q: '0};

  bmsl_st_t st_q; // Registered state.
  bmsl_st_t st_d; // Next state.
  logic q_in_ready; // Queue has room.
  logic q_out_valid; // Queue holds a descriptor.
  logic q_out_ready; // Output stage takes a descriptor.
  logic [bmsl_pkg::DESC_W-1:0] q_in; // Descriptor pushed.
  logic [bmsl_pkg::DESC_W-1:0] q_out; // Descriptor popped.
  logic push; // Descriptor produced this cycle.
  logic [15:0] chunk; // Bytes covered by this step.
  logic c_burst_n; // Step's burst indicator.
  logic c_ext; // Step's extended bit.
  logic [2:0] c_low; // Step's low size code.
  logic [7:0] c_lane; // Step's lanes.
  logic [2:0] off; // Byte offset inside the doubleword.
  logic [5:0] to_line; // Bytes left to the 32-byte line end.
  logic [3:0] room; // Bytes left to lane seven.
  logic [3:0] nsing; // Single-beat length.

  // ****************************************************************
  // Size choice for one step.
  // ****************************************************************
  // Largest legal size first; the queue keeps the bus side decoupled.
  always_comb begin
    off = st_q.addr_q[2:0];
    to_line = 6'h20 - {1'b0, st_q.addr_q[4:0]};
    room = 4'h8 - {1'b0, off};
    nsing = (st_q.rem_q < {12'h000, room}) ? st_q.rem_q[3:0] : room;
    chunk = {12'h000, nsing};
    c_burst_n = 1'b1;
    c_ext = 1'b0;
    c_low = nsing[2:0];
    // Lanes depend on offset and length only, never on endian mode.
    c_lane = (bmsl_pkg::ALL_LANES >> (4'h8 - nsing)) << off;
    if ((st_q.addr_q[4:0] & bmsl_pkg::LINE_MASK) == 5'h00 &&
        st_q.rem_q >= bmsl_pkg::BURST_BYTES) begin
      // Bursts only from a line start, so no wrapping burst occurs.
      chunk = bmsl_pkg::BURST_BYTES;
      c_burst_n = 1'b0;
      c_low = bmsl_pkg::LOW_BURST;
      c_lane = bmsl_pkg::ALL_LANES;
    end else if (st_q.ext_en_q && off == 3'h0 &&
        st_q.rem_q >= bmsl_pkg::EXT_TRI_BYTES &&
        {10'h000, to_line} >= bmsl_pkg::EXT_TRI_BYTES) begin
      chunk = bmsl_pkg::EXT_TRI_BYTES;
      c_ext = 1'b1;
      c_low = bmsl_pkg::LOW_EXT_TRI;
      c_lane = bmsl_pkg::ALL_LANES;
    end else if (st_q.ext_en_q && off == 3'h0 &&
        st_q.rem_q >= bmsl_pkg::EXT_DBL_BYTES &&
        {10'h000, to_line} >= bmsl_pkg::EXT_DBL_BYTES) begin
      chunk = bmsl_pkg::EXT_DBL_BYTES;
      c_ext = 1'b1;
      c_low = bmsl_pkg::LOW_EXT_DBL;
      c_lane = bmsl_pkg::ALL_LANES;
    end
  end

  assign push = st_q.busy_q && q_in_ready;
  assign q_in = {st_q.addr_q, c_burst_n, c_ext, c_low, c_lane};
  assign q_out_ready = !st_q.ov_q || TXN_READY;

  bmsl_fifo #(
    .WIDTH(bmsl_pkg::DESC_W),
    .DEPTH(DEPTH)
  ) u_queue (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(push),
    .in_ready(q_in_ready),
    .in_data(q_in),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_out)
  );

  // ****************************************************************
  // Splitter and output stage.
  // ****************************************************************
  // A full queue stalls the splitter; the bus stalls the queue.
  always_comb begin
    st_d = st_q;
    if (st_q.rdy_q && REQ_VALID && REQ_LEN != '0) begin
      st_d.busy_q = 1'b1;
      st_d.rdy_q = 1'b0;
      // Enable is caught per request so a mid-split change is safe.
      st_d.ext_en_q = EXTENDED_CYCLE_ENABLE;
      st_d.addr_q = REQ_ADDR;
      st_d.rem_q = REQ_LEN;
    end
    if (push) begin
      st_d.addr_q = st_q.addr_q + {16'h0000, chunk};
      st_d.rem_q = st_q.rem_q - chunk;
      if (st_q.rem_q == chunk) begin
        st_d.busy_q = 1'b0;
        st_d.rdy_q = 1'b1;
      end
    end
    if (q_out_ready) begin
      st_d.ov_q = q_out_valid;
      if (q_out_valid) begin
        {st_d.oaddr_q, st_d.oburst_n_q, st_d.oext_q, st_d.olow_q,
          st_d.olane_q} = q_out;
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= RESET_ST;
    end else begin
      st_q <= st_d;
    end
  end

  assign REQ_READY = st_q.rdy_q;
  assign BUSY = st_q.busy_q;
  assign TXN_VALID = st_q.ov_q;
  assign TXN_ADDR = st_q.oaddr_q;
  assign BURST_INDICATOR_N = st_q.oburst_n_q;
  assign EXTENDED_SIZE_BIT = st_q.oext_q;
  assign LOW_SIZE_CODE = st_q.olow_q;
  assign LANE_EN = st_q.olane_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_burst_code: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID && !BURST_INDICATOR_N |-> !EXTENDED_SIZE_BIT &&
      LOW_SIZE_CODE == 3'h2 && LANE_EN == 8'hff)
    else $error("Burst carries a wrong size code.");
  chk_ext_single: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID && EXTENDED_SIZE_BIT |-> BURST_INDICATOR_N)
    else $error("Extended cycle marked as burst.");
  chk_ext_gated: assert property (@(posedge CLK) disable iff (!RST_N)
    push && c_ext |-> st_q.ext_en_q)
    else $error("Extended cycle while extension disabled.");
  chk_ext_code: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID && EXTENDED_SIZE_BIT |-> TXN_ADDR[2:0] == 3'h0 &&
      (LOW_SIZE_CODE == 3'h1 || LOW_SIZE_CODE == 3'h2))
    else $error("Extended cycle with a bad code or offset.");
  chk_single_len: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID && BURST_INDICATOR_N && !EXTENDED_SIZE_BIT |->
      $countones(LANE_EN) ==
        ((LOW_SIZE_CODE == 3'h0) ? 8 : int'(LOW_SIZE_CODE)))
    else $error("Single-beat lanes do not match its size.");
  chk_lane_start: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID |-> LANE_EN[TXN_ADDR[2:0]] &&
      ((LANE_EN >> TXN_ADDR[2:0]) << TXN_ADDR[2:0]) == LANE_EN)
    else $error("Lanes do not start at the byte offset.");
  chk_burst_line: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID && !BURST_INDICATOR_N |-> TXN_ADDR[4:0] == 5'h00)
    else $error("Burst off a line boundary.");
  chk_split_step: assert property (@(posedge CLK) disable iff (!RST_N)
    push && st_q.rem_q != chunk |=>
      st_q.addr_q == $past(st_q.addr_q) + {16'h0000, $past(chunk)} &&
      st_q.busy_q)
    else $error("Split step did not advance by its size.");
  chk_txn_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID && !TXN_READY |=> TXN_VALID && $stable(TXN_ADDR) &&
      $stable(LANE_EN))
    else $error("Transaction changed while stalled.");
  // The size code and offset together must stay inside the doubleword.
  chk_single_fits: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID && BURST_INDICATOR_N && !EXTENDED_SIZE_BIT |->
      int'(TXN_ADDR[2:0]) +
        ((LOW_SIZE_CODE == 3'h0) ? 8 : int'(LOW_SIZE_CODE)) <= 8)
    else $error("Single beat runs past the last lane.");
  // Adding the lowest lane bit to one contiguous run leaves one bit set.
  chk_lane_run: assert property (@(posedge CLK) disable iff (!RST_N)
    TXN_VALID |-> $onehot({1'b0, LANE_EN} + (9'h001 << TXN_ADDR[2:0])))
    else $error("Lanes in use are not one contiguous run.");
endmodule : bmsl_size_lane_encoder
`default_nettype wire

/* testbench/bmsl_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Slave side: takes descriptors, stalls at random or on command.
// ****************************************************************
module bmsl_slave_model (
  input wire logic clk, // Bus clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic stall, // Holds off every descriptor.
  input wire logic txn_valid, // Descriptor offered.
  input wire logic ext_bit, // Offered descriptor is extended.
  input wire logic [2:0] low_code, // Offered low size code.
  output logic txn_ready // Takes the offered descriptor.
);
  logic [1:0] beats_left; // Quantities still to strobe.

  // A random ready pattern proves the master holds its offer stable.
  // Every slave takes the full 64-bit width, so no port sizing here.
  // An extended cycle keeps the slave busy for one strobe per quantity.
  always @(posedge clk) begin
    if (!rst_n) begin
      beats_left <= 2'h0;
      txn_ready <= 1'b0;
    end else if (txn_valid && txn_ready && ext_bit) begin
      // Code 001 leaves one more quantity, code 010 two; ready stays low until they pass.
      beats_left <= low_code[1:0];
      txn_ready <= 1'b0;
    end else if (beats_left != 2'h0) begin
      beats_left <= beats_left - 2'h1;
      txn_ready <= 1'b0;
    end else begin
      txn_ready <= !stall && ($urandom % 4 != 0);
    end
  end
endmodule : bmsl_slave_model

`default_nettype wire

/* testbench/tb_bmsl_size_lane_encoder.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Bench for the size and lane encoder.
// ****************************************************************
module tb_bmsl_size_lane_encoder;
  logic clk = 1'b0; // Bus clock.
  logic rst_n = 1'b0; // Reset, active low.
  logic ext_en = 1'b0; // Extended cycles allowed.
  logic req_valid = 1'b0; // Request offered.
  logic [31:0] req_addr = 32'h0; // Request address.
  logic [15:0] req_len = 16'h0; // Request length.
  logic stall = 1'b0; // Slave refuses everything.
  logic req_ready, busy, txn_valid, txn_ready; // Handshakes.
  logic burst_n, ext_bit; // Size flags.
  logic [2:0] low_code; // Low size code.
  logic [7:0] lane_en; // Lanes in use.
  logic [31:0] txn_addr; // Piece address.
  logic [bmsl_pkg::DESC_W-1:0] exp_q[$]; // Expected pieces, oldest first.
  int fail_count = 0; // Mismatches.
  int comparisons = 0; // Checks made.
  int cycles = 0; // Hang guard.

  bmsl_size_lane_encoder #(.DEPTH(8)) dut (
    .CLK(clk), .RST_N(rst_n), .EXTENDED_CYCLE_ENABLE(ext_en),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_ADDR(req_addr),
    .REQ_LEN(req_len), .BUSY(busy), .TXN_VALID(txn_valid),
    .TXN_READY(txn_ready), .TXN_ADDR(txn_addr),
    .BURST_INDICATOR_N(burst_n), .EXTENDED_SIZE_BIT(ext_bit),
    .LOW_SIZE_CODE(low_code), .LANE_EN(lane_en));

  bmsl_slave_model slave (.clk(clk), .rst_n(rst_n), .stall(stall),
    .txn_valid(txn_valid), .ext_bit(ext_bit), .low_code(low_code),
    .txn_ready(txn_ready));

  // The clock toggles every 5 ns for a 100 MHz rate.
  initial forever #5 clk = ~clk;

  // Closing report; the only place the run ends.
  task automatic give_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Compares a seen value with the expected one and counts both.
  task automatic check(input string name,
    input logic [bmsl_pkg::DESC_W-1:0] seen,
    input logic [bmsl_pkg::DESC_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Offers one request and notes the pieces a legal splitter makes.
  task automatic send(input logic [31:0] addr, input int len,
    input logic ext);
    logic [31:0] a;
    int rem;
    int n;
    logic [8:0] m;
    logic [2:0] off;
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= addr;
    req_len <= len[15:0];
    ext_en <= ext;
    @(posedge clk);
    req_valid <= 1'b0;
    a = addr;
    rem = len;
    // Largest legal piece first keeps the bus transaction count low.
    while (rem > 0) begin
      off = a[2:0];
      if (a[4:0] == 5'h00 && rem >= 32) begin
        n = 32;
        exp_q.push_back({a, 2'h0, bmsl_pkg::LOW_BURST,
          bmsl_pkg::ALL_LANES});
      end else if (ext && off == 3'h0 && rem >= 16
        && 32 - a[4:0] >= 16) begin
        n = (rem >= 24 && 32 - a[4:0] >= 24) ? 24 : 16;
        exp_q.push_back({a, 2'h3, (n == 24) ? bmsl_pkg::LOW_EXT_TRI :
          bmsl_pkg::LOW_EXT_DBL, bmsl_pkg::ALL_LANES});
      end else begin
        n = (rem < 8 - off) ? rem : 8 - off;
        m = (9'h001 << n) - 9'h001;
        exp_q.push_back({a, 2'h2, n[2:0], m[7:0] << off});
      end
      a = a + n;
      rem = rem - n;
    end
  endtask : send

  // Watches the slave side; each taken piece meets its oldest note.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end else if (rst_n === 1'b1 && txn_valid === 1'b1 &&
        txn_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare piece", 'h1, 'h0);
      end else begin
        check("piece", {txn_addr, burst_n, ext_bit, low_code, lane_en},
          exp_q.pop_front());
      end
    end
  end

  // Main sequence: reset, documented walks, every single, random, stall.
  initial begin
    void'($urandom(93918));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("idle valid", txn_valid, 'h0);
    check("idle burst flag", burst_n, 'h1);
    send(32'h4, 60, 1'b1);
    send(32'h4, 60, 1'b0);
    send(32'h10, 0, 1'b1);
    @(posedge clk);
    check("ready after empty", req_ready, 'h1);
    // Every size at every legal offset, lanes one to eight bytes.
    for (int n = 1; n <= 8; n++) begin
      for (int k = 0; k <= 8 - n; k++) begin
        send(32'h100 + k, n, 1'b0);
      end
    end
    repeat (40) begin
      send($urandom % 32'h10000, 1 + $urandom % 100, 1'($urandom % 2));
    end
    // A long request with the slave stalled fills the queue.
    stall <= 1'b1;
    send(32'h1, 256, 1'b0);
    repeat (30) @(posedge clk);
    check("busy while full", busy, 'h1);
    stall <= 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    check("queue drained", exp_q.size() == 0, 'h1);
    check("valid when empty", txn_valid, 'h0);
    give_verdict();
  end
endmodule : tb_bmsl_size_lane_encoder

`default_nettype wire
